// ---- logic/cbr_pkg.sv ----
/*
 * Shared constants, state codes and carrier structs for the host register
 * port of the message bridge. Assumes a single 100 MHz clock domain.
 */
`default_nettype none

package cbr_pkg;
    // ------------------------------------------------------------------
    // Slave address
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_DEVICE_CODE = 4'h6;
    localparam logic       ADDR_FIXED_B3    = 1'h1;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFF_POINTER    = 5'h00;
    localparam logic [4:0] OFF_FAULT      = 5'h01;
    localparam logic [4:0] OFF_REVISION   = 5'h02;
    localparam logic [4:0] OFF_CONTROL    = 5'h03;
    localparam logic [4:0] OFF_ACK_UPPER  = 5'h04;
    localparam logic [4:0] OFF_ACK_LOWER  = 5'h05;
    localparam logic [4:0] OFF_LINK_CFG   = 5'h06;
    localparam logic [4:0] OFF_DATA_FIRST = 5'h07;
    localparam logic [4:0] OFF_DATA_LAST  = 5'h19;
    localparam logic [4:0] PTR_SATURATE   = 5'h1f;
    localparam logic [4:0] PTR_STEP       = 5'h01;

    // ------------------------------------------------------------------
    // Fields, codes and reset values
    // ------------------------------------------------------------------
    localparam int         PTR_MSB        = 4;
    localparam logic [4:0] STATUS_UNUSED  = 5'h00;
    localparam logic [7:0] FAULT_NONE     = 8'h00;
    localparam logic [7:0] FAULT_WATCHDOG = 8'h01;
    localparam logic [7:0] FAULT_LONG_MSG = 8'h02;
    localparam logic [7:0] FAULT_OVERRUN  = 8'h03;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [7:0] INVALID_READ   = 8'hff;
    localparam logic       POL_RESET      = 1'h1;
    localparam logic [1:0] STRAP_SETTLE   = 2'h2;
    localparam logic [2:0] BIT_LAST       = 3'h7;

    // ------------------------------------------------------------------
    // Serial engine states
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE     = 7'h01,
        S_ADDR     = 7'h02,
        S_ADDR_ACK = 7'h04,
        S_WR_BYTE  = 7'h08,
        S_WR_ACK   = 7'h10,
        S_RD_BYTE  = 7'h20,
        S_RD_ACK   = 7'h40
    } cbr_fsm_type;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
        logic addr_hi;
        logic addr_lo;
        logic pol;
    } cbr_pins_type;

    typedef struct packed {
        cbr_fsm_type fsm;
        logic        scl_q;
        logic        sda_q;
        logic [2:0]  cnt;
        logic        done;
        logic        rw;
        logic        first;
        logic        nack;
        logic [7:0]  sh;
        logic [7:0]  tx;
        logic [4:0]  ptr;
        logic        sda_oe;
        logic        sda_o;
        logic [7:0]  ctrl;
        logic [7:0]  ack_hi;
        logic [7:0]  ack_lo;
        logic [7:0]  cfg;
        logic [7:0]  fault;
        logic        err;
        logic        busy;
        logic        irq_on;
        logic        irq;
        logic        pol;
        logic [1:0]  settle;
        logic        pol_done;
        logic        dwr;
        logic        drd;
        logic [4:0]  didx;
        logic [7:0]  dwdata;
    } cbr_state_type;
endpackage : cbr_pkg

`default_nettype wire

// ---- logic/cbr_sync.sv ----
/*
 * Two-flop synchroniser for a group of asynchronous pin inputs.
 * Assumes the inputs are slow levels against the sampling clock.
 */
`default_nettype none

module cbr_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Pins in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } cbr_sync_state_type;

    cbr_sync_state_type st;
    cbr_sync_state_type next_st;

    if (WIDTH < 1) begin : g_check
        $error("cbr_sync needs at least one bit");
    end

    // The meta stage feeds only the stable stage
    always_comb begin
        next_st        = st;
        next_st.meta   = i_async;
        next_st.stable = st.meta;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.stable;
endmodule : cbr_sync

`default_nettype wire

// ---- logic/cbr_port.sv ----
/*
 * Host register port: serial slave, pointer, register file, status and
 * interrupt pin. Assumes SCL/SDA far slower than the 100 MHz clock, and
 * a message core on the same clock providing busy, interrupt request,
 * error events and data-window read bytes.
 */
`default_nettype none

// Functional notes
// - Answer at address 0110 1, hi strap, lo strap; last bit is R/W.
// - Address and data bytes travel most significant bit first.
// - Serial clock is only sampled, never driven or stretched.
// - First written data byte loads the pointer for the transfer.
// - Reads without pointer write start at the last pointer value.
// - Pointer advances after each completed byte, except at zero and at 1f.
// - Pointer past last data location: writes dropped, only the pointer advances.
// - Pointer writes above first data location clamp to it.
// - Offsets 1 to 6: fault, revision, control, ack maps, config.
// - Offset zero writes pointer, reads device status.
// - Pointer field is bits four to zero; host writes upper bits zero.
// - Status bit 7 shows busy.
// - Status bit 6 shows interrupt active, regardless of polarity.
// - Status bit 5 set on error, cleared by reading fault code.
// - Fault code holds latest error code from the core.
// - Revision shows major in upper nibble, minor in lower.
// - Active interrupt equals polarity strap level, inactive opposite.
// - Polarity strap captured after reset and held until next reset.
// - Interrupt asserted while data waits for the host.
module cbr_port #(
    parameter logic [3:0] MAJOR_REV = 4'h1,
    parameter logic [3:0] MINOR_REV = 4'h0
) (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Serial bus pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output var  logic       o_sda_out,
    output var  logic       o_sda_oe,
    // Straps
    input  wire logic       i_addr_strap_hi,
    input  wire logic       i_addr_strap_lo,
    input  wire logic       i_irq_polarity_strap,
    // Message core status
    input  wire logic       i_busy,
    input  wire logic       i_irq_request,
    input  wire logic       i_error_valid,
    input  wire logic [7:0] i_error_code,
    // Data window
    input  wire logic [7:0] i_data_rdata,
    output var  logic [4:0] o_register_pointer,
    output var  logic [4:0] o_data_index,
    output var  logic       o_data_write,
    output var  logic       o_data_read,
    output var  logic [7:0] o_data_wdata,
    // Configuration out, interrupt pin
    output var  logic [7:0] o_device_control,
    output var  logic [7:0] o_ack_map_upper,
    output var  logic [7:0] o_ack_map_lower,
    output var  logic [7:0] o_link_config,
    output var  logic       o_irq
);
    cbr_pkg::cbr_state_type st;
    cbr_pkg::cbr_state_type next_st;
    cbr_pkg::cbr_pins_type  pins;
    cbr_pkg::cbr_pins_type  pins_s;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign pins = '{scl: i_scl, sda: i_sda, addr_hi: i_addr_strap_hi,
                    addr_lo: i_addr_strap_lo, pol: i_irq_polarity_strap};

    cbr_sync #(
        .WIDTH ($bits(cbr_pkg::cbr_pins_type))
    ) u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (pins),
        .o_sync  (pins_s)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] bump_pointer(input logic [4:0] p);
        if (p == cbr_pkg::OFF_POINTER || p == cbr_pkg::PTR_SATURATE) begin
            return p;
        end
        return p + cbr_pkg::PTR_STEP;
    endfunction : bump_pointer

    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic [6:0] my_addr;

    // Clock is sampled only; there is no SCL output at all
    assign scl_rise   = pins_s.scl & ~st.scl_q;
    assign scl_fall   = ~pins_s.scl & st.scl_q;
    assign start_seen = pins_s.scl & st.scl_q & st.sda_q & ~pins_s.sda;
    assign stop_seen  = pins_s.scl & st.scl_q & ~st.sda_q & pins_s.sda;
    assign my_addr    = {cbr_pkg::ADDR_DEVICE_CODE, cbr_pkg::ADDR_FIXED_B3,
                         pins_s.addr_hi, pins_s.addr_lo};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] rd_byte;
        rd_byte = cbr_pkg::INVALID_READ;
        next_st = st;
        next_st.scl_q  = pins_s.scl;
        next_st.sda_q  = pins_s.sda;
        next_st.sda_o  = 1'h0;
        next_st.dwr    = 1'h0;
        next_st.drd    = 1'h0;
        next_st.busy   = i_busy;
        next_st.irq_on = i_irq_request;

        // Strap is taken once, after it has crossed the synchroniser
        if (!st.pol_done) begin
            next_st.settle = st.settle + 2'h1;
            if (st.settle == cbr_pkg::STRAP_SETTLE) begin
                next_st.pol      = pins_s.pol;
                next_st.pol_done = 1'h1;
            end
        end
        next_st.irq = next_st.irq_on ? next_st.pol : ~next_st.pol;

        // Read mux
        case (st.ptr)
            cbr_pkg::OFF_POINTER: rd_byte = {st.busy, st.irq_on, st.err,
                cbr_pkg::STATUS_UNUSED};
            cbr_pkg::OFF_FAULT:     rd_byte = st.fault;
            cbr_pkg::OFF_REVISION: rd_byte = {MAJOR_REV, MINOR_REV};
            cbr_pkg::OFF_CONTROL:   rd_byte = st.ctrl;
            cbr_pkg::OFF_ACK_UPPER: rd_byte = st.ack_hi;
            cbr_pkg::OFF_ACK_LOWER: rd_byte = st.ack_lo;
            cbr_pkg::OFF_LINK_CFG:  rd_byte = st.cfg;
            default: begin
                if (st.ptr <= cbr_pkg::OFF_DATA_LAST) begin
                    rd_byte = i_data_rdata;
                end
            end
        endcase

        // Byte engine, bits sampled on the rising, driven on the falling clock edge
        if (scl_rise) begin
            case (st.fsm)
                cbr_pkg::S_ADDR, cbr_pkg::S_WR_BYTE, cbr_pkg::S_RD_BYTE: begin
                    next_st.sh   = {st.sh[6:0], pins_s.sda};
                    next_st.cnt  = st.cnt + 3'h1;
                    next_st.done = (st.cnt == cbr_pkg::BIT_LAST);
                end
                cbr_pkg::S_RD_ACK: begin
                    next_st.nack = pins_s.sda;
                end
                default: begin
                end
            endcase
        end

        if (scl_fall) begin
            case (st.fsm)
                cbr_pkg::S_ADDR: begin
                    if (st.done) begin
                        next_st.done = 1'h0;
                        if (st.sh[7:1] == my_addr) begin
                            next_st.fsm    = cbr_pkg::S_ADDR_ACK;
                            next_st.rw     = st.sh[0];
                            next_st.sda_oe = 1'h1;
                        end else begin
                            next_st.fsm = cbr_pkg::S_IDLE;
                        end
                    end
                end
                cbr_pkg::S_ADDR_ACK, cbr_pkg::S_RD_ACK: begin
                    next_st.cnt  = 3'h0;
                    next_st.done = 1'h0;
                    if (st.fsm == cbr_pkg::S_ADDR_ACK && !st.rw) begin
                        next_st.sda_oe = 1'h0;
                        next_st.fsm    = cbr_pkg::S_WR_BYTE;
                    end else if (st.fsm == cbr_pkg::S_RD_ACK && st.nack) begin
                        next_st.sda_oe = 1'h0;
                        next_st.fsm    = cbr_pkg::S_IDLE;
                    end else begin
                        // Starts at whatever the pointer last held
                        next_st.tx     = rd_byte;
                        next_st.sda_oe = ~rd_byte[7];
                        next_st.fsm    = cbr_pkg::S_RD_BYTE;
                    end
                end
                cbr_pkg::S_RD_BYTE: begin
                    if (st.done) begin
                        next_st.done   = 1'h0;
                        next_st.sda_oe = 1'h0;
                        next_st.nack   = 1'h0;
                        next_st.fsm    = cbr_pkg::S_RD_ACK;
                        next_st.ptr    = bump_pointer(st.ptr);
                        if (st.ptr == cbr_pkg::OFF_FAULT) begin
                            next_st.err = 1'h0;
                        end
                        if (st.ptr >= cbr_pkg::OFF_DATA_FIRST &&
                            st.ptr <= cbr_pkg::OFF_DATA_LAST) begin
                            next_st.drd  = 1'h1;
                            next_st.didx = st.ptr - cbr_pkg::OFF_DATA_FIRST;
                        end
                    end else begin
                        next_st.tx     = {st.tx[6:0], 1'h0};
                        next_st.sda_oe = ~st.tx[6];
                    end
                end
                cbr_pkg::S_WR_BYTE: begin
                    if (st.done) begin
                        next_st.done   = 1'h0;
                        next_st.sda_oe = 1'h1;
                        next_st.fsm    = cbr_pkg::S_WR_ACK;
                        if (st.first) begin
                            // Upper bits are the host's to keep zero
                            next_st.first = 1'h0;
                            next_st.ptr = st.sh[cbr_pkg::PTR_MSB:0];
                            if (st.sh[cbr_pkg::PTR_MSB:0] >
                                cbr_pkg::OFF_DATA_FIRST) begin
                                next_st.ptr = cbr_pkg::OFF_DATA_FIRST;
                            end
                        end else if (st.ptr <= cbr_pkg::OFF_DATA_LAST) begin
                            next_st.ptr = bump_pointer(st.ptr);
                            case (st.ptr)
                                cbr_pkg::OFF_CONTROL:   next_st.ctrl   = st.sh;
                                cbr_pkg::OFF_ACK_UPPER: next_st.ack_hi = st.sh;
                                cbr_pkg::OFF_ACK_LOWER: next_st.ack_lo = st.sh;
                                cbr_pkg::OFF_LINK_CFG:  next_st.cfg    = st.sh;
                                default: begin
                                    if (st.ptr > cbr_pkg::OFF_LINK_CFG) begin
                                        next_st.dwr    = 1'h1;
                                        next_st.dwdata = st.sh;
                                        next_st.didx   = st.ptr -
                                            cbr_pkg::OFF_DATA_FIRST;
                                    end
                                end
                            endcase
                        end else begin
                            // Out of range: byte acknowledged, then dropped
                            next_st.ptr = bump_pointer(st.ptr);
                        end
                    end
                end
                cbr_pkg::S_WR_ACK: begin
                    next_st.sda_oe = 1'h0;
                    next_st.cnt    = 3'h0;
                    next_st.fsm    = cbr_pkg::S_WR_BYTE;
                end
                default: begin
                end
            endcase
        end

        if (start_seen || stop_seen) begin
            next_st.fsm    = start_seen ? cbr_pkg::S_ADDR : cbr_pkg::S_IDLE;
            next_st.sda_oe = 1'h0;
            next_st.cnt    = 3'h0;
            next_st.done   = 1'h0;
            next_st.first  = 1'h1;
        end

        // A new error wins over the clear by read
        if (i_error_valid) begin
            next_st.fault = i_error_code;
            next_st.err   = 1'h1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st          <= '0;
            st.fsm      <= cbr_pkg::S_IDLE;
            st.scl_q    <= 1'h1;
            st.sda_q    <= 1'h1;
            st.first    <= 1'h1;
            st.ctrl     <= cbr_pkg::REG_RESET;
            st.ack_hi   <= cbr_pkg::REG_RESET;
            st.ack_lo   <= cbr_pkg::REG_RESET;
            st.cfg      <= cbr_pkg::REG_RESET;
            st.fault    <= cbr_pkg::FAULT_NONE;
            st.pol      <= cbr_pkg::POL_RESET;
            st.irq      <= ~cbr_pkg::POL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_sda_out          = st.sda_o;
    assign o_sda_oe           = st.sda_oe;
    assign o_register_pointer = st.ptr;
    assign o_data_index       = st.didx;
    assign o_data_write       = st.dwr;
    assign o_data_read        = st.drd;
    assign o_data_wdata       = st.dwdata;
    assign o_device_control   = st.ctrl;
    assign o_ack_map_upper    = st.ack_hi;
    assign o_ack_map_lower    = st.ack_lo;
    assign o_link_config      = st.cfg;
    assign o_irq              = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    logic wr_done;
    assign wr_done = scl_fall && st.done && st.fsm == cbr_pkg::S_WR_BYTE;

    addr_match_a: assert property (
        st.fsm == cbr_pkg::S_ADDR && scl_fall && st.done && !start_seen
        && !stop_seen |=> (st.fsm == cbr_pkg::S_ADDR_ACK) ==
        ($past(st.sh[7:1]) == $past(my_addr)))
        else $error("address match wrong");
    ptr_load_a: assert property (
        wr_done && st.first && !start_seen && !stop_seen |=> st.ptr ==
        (($past(st.sh[4:0]) > cbr_pkg::OFF_DATA_FIRST) ?
        cbr_pkg::OFF_DATA_FIRST : $past(st.sh[4:0])))
        else $error("pointer load wrong");
    ptr_zero_hold_a: assert property (
        st.ptr == cbr_pkg::OFF_POINTER && !(wr_done && st.first)
        |=> st.ptr == cbr_pkg::OFF_POINTER)
        else $error("pointer left zero");
    invalid_write_a: assert property (
        wr_done && !st.first && st.ptr > cbr_pkg::OFF_DATA_LAST
        |=> $stable(st.ctrl) && $stable(st.cfg) && !st.dwr)
        else $error("out of range write took effect");
    pointer_only_a: assert property (
        wr_done && st.first |=> $stable(st.ctrl) && $stable(st.ack_hi)
        && $stable(st.ack_lo) && $stable(st.cfg) && !st.dwr)
        else $error("pointer byte changed a register");
    status_load_a: assert property (
        st.fsm == cbr_pkg::S_ADDR_ACK && scl_fall && st.rw && !start_seen
        && !stop_seen && st.ptr == cbr_pkg::OFF_POINTER
        |=> st.tx[7:6] == $past({st.busy, st.irq_on}))
        else $error("status bits wrong");
    err_clear_a: assert property (
        scl_fall && st.done && st.fsm == cbr_pkg::S_RD_BYTE && !start_seen
        && !stop_seen && st.ptr == cbr_pkg::OFF_FAULT && !i_error_valid
        |=> !st.err)
        else $error("error flag not cleared");
    err_set_a: assert property (
        i_error_valid |=> st.err && st.fault == $past(i_error_code))
        else $error("error not recorded");
    irq_level_a: assert property (
        i_irq_request |=> o_irq == st.pol ##1 1'h1)
        else $error("interrupt level wrong");
    pol_hold_a: assert property (
        st.pol_done |=> $stable(st.pol) [*4])
        else $error("polarity changed after capture");
endmodule : cbr_port

`default_nettype wire

// ---- verification/cbr_host_model.sv ----
/*
 * Bus master model of the host: start, stop and byte transfers.
 * Assumes the bench resolves the open-drain data wire into i_sda.
 */
`default_nettype none

module cbr_host_model (
    // Clock and data wire
    input  wire logic       i_clock,
    input  wire logic       i_sda,
    // Driven pins and read result
    output var  logic       o_scl,
    output var  logic       o_sda_low,
    output var  logic [7:0] o_rd_data,
    output var  logic       o_rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_scl = 1'h1;
        o_sda_low = 1'h0;
        o_rd_data = 8'h00;
        o_rd_valid = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    // Quarter of four clocks gives a 160 ns serial clock period
    task automatic start;
        o_sda_low = 1'h0;
        tick(4);
        o_scl = 1'h1;
        tick(4);
        o_sda_low = 1'h1;
        tick(4);
        o_scl = 1'h0;
    endtask : start
    task automatic stop;
        tick(4);
        o_sda_low = 1'h1;
        tick(4);
        o_scl = 1'h1;
        tick(4);
        o_sda_low = 1'h0;
        tick(8);
    endtask : stop
    task automatic xbit(input logic b, output logic r);
        tick(4);
        o_sda_low = ~b;
        tick(4);
        o_scl = 1'h1;
        tick(4);
        r = i_sda;
        tick(4);
        o_scl = 1'h0;
    endtask : xbit
    task automatic xbyte(input logic [7:0] d, input logic ab,
                         output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(ab, a);
    endtask : xbyte
    task automatic rbyte(input logic nack);
        logic a;
        xbyte(8'hff, nack, o_rd_data, a);
        o_rd_valid = 1'h1;
        tick(1);
        o_rd_valid = 1'h0;
    endtask : rbyte
endmodule : cbr_host_model

`default_nettype wire

// ---- verification/cbr_tb.sv ----
/*
 * Self-checking bench of the host register port.
 * Assumes cbr_port and cbr_host_model are compiled before it.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, hi, lo, pol, p0, busy = 0, irq_rq = 0;
    logic err_v = 0, scl, sda_low, rd_v, oe, so, irq, dwr, drd, a;
    logic [7:0] err_c = 0, rdat, rd_d, ctl, ah, al, cfg, dwd, q;
    logic [7:0] r[3], expq[$];
    logic [4:0] ptr, didx;
    int err_total = 0, compares = 0;
    int n_dwr = 0, n_drd = 0;
    logic [7:0] wd_seen, wq[$];
    logic [4:0] wi_seen;
    wire sda = ~(oe | sda_low);
    always #5 clk = ~clk;
    cbr_port i_cbr_port (.i_clock(clk), .i_rst_n(rst_n), .i_scl(scl),
        .i_sda(sda), .o_sda_out(so), .o_sda_oe(oe), .i_addr_strap_hi(hi),
        .i_addr_strap_lo(lo), .i_irq_polarity_strap(pol), .i_busy(busy),
        .i_irq_request(irq_rq), .i_error_valid(err_v),
        .i_error_code(err_c), .i_data_rdata(rdat), .o_register_pointer(ptr),
        .o_data_index(didx), .o_data_write(dwr), .o_data_read(drd),
        .o_data_wdata(dwd), .o_device_control(ctl), .o_ack_map_upper(ah),
        .o_ack_map_lower(al), .o_link_config(cfg), .o_irq(irq));
    cbr_host_model i_cbr_host_model (.i_clock(clk), .i_sda(sda),
        .o_scl(scl), .o_sda_low(sda_low), .o_rd_data(rd_d),
        .o_rd_valid(rd_v));
    task automatic check(input string n, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask : check
    task automatic conclude;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic adr(input logic rw, input logic h, input logic ea);
        i_cbr_host_model.start();
        i_cbr_host_model.xbyte({4'h6, 1'h1, h, lo, rw}, 1'h1, q, a);
        check("addr_ack", {7'h0, a}, {7'h0, ea});
    endtask : adr
    // Upper pointer bits always written zero
    task automatic wr(input logic [7:0] b[$]);
        adr(1'h0, hi, 1'h0);
        foreach (b[i]) i_cbr_host_model.xbyte(b[i], 1'h1, q, a);
        i_cbr_host_model.stop();
    endtask : wr
    task automatic rd(input logic [7:0] e[$]);
        adr(1'h1, hi, 1'h0);
        foreach (e[i]) begin
            expq.push_back(e[i]);
            i_cbr_host_model.rbyte(i == e.size() - 1);
        end
        i_cbr_host_model.stop();
    endtask : rd
    always @(negedge clk) if (rd_v) check("read", rd_d, expq.pop_front());
    // Data window pulses, sampled away from the launching edge
    always @(negedge clk) begin
        if (dwr) begin
            n_dwr++;
            wd_seen = dwd;
            wi_seen = didx;
        end
        if (drd) n_drd++;
    end
    initial begin
        #500_000;
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(21079));
        {hi, lo, p0} = 3'($urandom);
        pol = p0;
        rdat = 8'($urandom);
        foreach (r[i]) r[i] = 8'($urandom);
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        repeat (10) @(posedge clk);
        #1 pol = ~p0;
        check("irq_idle", {7'h0, irq}, {7'h0, ~p0});
        rd('{8'h00, 8'h00});
        wr('{8'h03, r[0], r[1], r[2]});
        check("ctl", ctl, r[0]);
        check("ack_upper", ah, r[1]);
        check("ack_lower", al, r[2]);
        wr('{8'h01});
        rd('{8'h00, 8'h10, r[0]});
        rd('{r[1]});
        for (int c = 1; c < 4; c++) begin
            err_c = 8'(c);
            err_v = 1;
            @(posedge clk);
            #1 err_v = 0;
            wr('{8'h00});
            rd('{8'h20});
            wr('{8'h01});
            rd('{8'(c), 8'h10});
            wr('{8'h00});
            rd('{8'h00});
        end
        busy = 1;
        irq_rq = 1;
        wr('{8'h00});
        check("irq_on", {7'h0, irq}, {7'h0, p0});
        rd('{8'hc0});
        wr('{8'h1f});
        check("ptr", {3'h0, ptr}, 8'h07);
        rd('{rdat});
        check("data_read", 8'(n_drd), 8'h01);
        check("data_index", {3'h0, didx}, 8'h00);
        wr('{8'h06, r[2]});
        check("cfg", cfg, r[2]);
        wq.push_back(8'h07);
        repeat (20) wq.push_back(8'($urandom));
        wr(wq);
        check("data_writes", 8'(n_dwr), 8'h13);
        check("data_wdata", wd_seen, wq[19]);
        check("data_windex", {3'h0, wi_seen}, 8'h12);
        check("ptr_past", {3'h0, ptr}, 8'h1b);
        check("cfg_kept", cfg, r[2]);
        check("ctl_kept", ctl, r[0]);
        rd('{8'hff});
        check("sda_out", {7'h0, so}, 8'h00);
        adr(1'h0, ~hi, 1'h1);
        i_cbr_host_model.stop();
        conclude();
    end
endmodule : testbench

`default_nettype wire
